// ===== pkg/urnf_cfg.svh
`ifndef URNF_CFG_SVH
`define URNF_CFG_SVH
// ----------------------------------------
// filter lengths in oscillator periods
// ----------------------------------------
`define URNF_FLT_LEN_01     7'h1F
`define URNF_FLT_LEN_10     7'h3F
`define URNF_FLT_LEN_11     7'h7F
// ----------------------------------------
// baud source codes, fixed divider and idle line level
// ----------------------------------------
`define URNF_BSEL_FIXED    3'h0
`define URNF_BSEL_TIMER    3'h6
`define URNF_FIXED_DIV     5'h0D
`define URNF_RX_IDLE       1'h1
`endif

// ===== pkg/urnf_pkg.sv
`default_nettype none
package urnf_pkg;
  typedef enum logic [1:0] {
    URNF_FLT_OFF = 2'h0,
    URNF_FLT_31  = 2'h1,
    URNF_FLT_63  = 2'h2,
    URNF_FLT_127 = 2'h3
  } urnf_flt_e;
  typedef logic [6:0] urnf_cnt_t;
endpackage : urnf_pkg
`default_nettype wire

// ===== design/urnf_baud_gen.sv
`include "urnf_cfg.svh"
`default_nettype none
module urnf_baud_gen #(
  parameter int TW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic [2:0]    baud_source_sel,
  input  wire logic          timer_src_tick,
  input  wire logic [TW-1:0] timer_compare_value,
  output logic               xfer_clk_tick
);
  // ----------------------------------------
  // dividers
  // ----------------------------------------
  logic [4:0]    fdiv;
  logic [4:0]    next_fdiv;
  logic [TW-1:0] tcnt;
  logic [TW-1:0] next_tcnt;
  logic          next_tick;
  logic          fwrap;
  logic          twrap;

  always_comb begin
    fwrap     = (fdiv == `URNF_FIXED_DIV - 5'h01);
    next_fdiv = fwrap ? 5'h00 : fdiv + 5'h01;                            // RL4
    // compare of 0 treated as 1: no stall
    twrap     = timer_src_tick && (tcnt + {{(TW-1){1'b0}}, 1'b1} >= timer_compare_value);
    next_tcnt = tcnt;
    if (timer_src_tick) begin
      next_tcnt = twrap ? '0 : tcnt + {{(TW-1){1'b0}}, 1'b1};           // RL3
    end
    case (baud_source_sel)
      `URNF_BSEL_FIXED: next_tick = fwrap;                              // RL4
      `URNF_BSEL_TIMER: next_tick = twrap;                              // RL3
      default:          next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fdiv          <= 5'h00;
      tcnt          <= '0;
      xfer_clk_tick <= 1'b0;
    end else begin
      fdiv          <= next_fdiv;
      tcnt          <= next_tcnt;
      xfer_clk_tick <= next_tick;
    end
  end

  // ----------------------------------------
  // fixed period monitor
  // ----------------------------------------
  // fdiv runs in every mode, so the gap is trusted only after a tick that
  // came while the fixed source was already selected
  logic [4:0] gap;
  logic [4:0] next_gap;
  logic       gap_ok;
  logic       next_gap_ok;
  logic       fix_was;
  logic       next_fix_was;

  always_comb begin
    next_fix_was = (baud_source_sel == `URNF_BSEL_FIXED);
    next_gap_ok  = next_fix_was && (gap_ok || (xfer_clk_tick && fix_was));
    // saturates so a silent source cannot wrap the gap back into range
    next_gap     = xfer_clk_tick ? 5'h01 : gap + {4'h0, ~&gap};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gap     <= 5'h00;
      gap_ok  <= 1'b0;
      fix_was <= 1'b0;
    end else begin
      gap     <= next_gap;
      gap_ok  <= next_gap_ok;
      fix_was <= next_fix_was;
    end
  end

  fixed_period_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    gap_ok && xfer_clk_tick |-> (gap == `URNF_FIXED_DIV))
    else $error("fixed divider period not 13"); // RL4
  fixed_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    gap_ok |-> (gap <= `URNF_FIXED_DIV))
    else $error("fixed divider tick went missing"); // RL4
endmodule : urnf_baud_gen
`default_nettype wire

// ===== design/urnf_rx_filter.sv
// Behaviour
// RL1: 00 bypasses; 01 rejects under 31 periods
// RL2: 10 rejects under 63; 11 under 127
// RL3: timer clock equals source over compare value
// RL4: code 110 timer, code 000 fc/13
// RL5: software avoids barred filter/clock pairs
// RL6: level passes after stable count, restart on change
`include "urnf_cfg.svh"
`default_nettype none
module urnf_rx_filter #(
  parameter int TW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          rx_line,
  input  wire logic [1:0]    rx_noise_filter_sel,
  input  wire logic [2:0]    baud_source_sel,
  input  wire logic          timer_src_tick,
  input  wire logic [TW-1:0] timer_compare_value,
  output logic               rx_filtered,
  output logic               xfer_clk_tick
);
  // ----------------------------------------
  // noise filter
  // ----------------------------------------
  urnf_pkg::urnf_cnt_t cnt;
  urnf_pkg::urnf_cnt_t next_cnt;
  urnf_pkg::urnf_cnt_t flt_len;
  logic                cand;
  logic                next_cand;
  logic                next_rx;

  always_comb begin
    case (urnf_pkg::urnf_flt_e'(rx_noise_filter_sel))
      urnf_pkg::URNF_FLT_31:  flt_len = `URNF_FLT_LEN_01;                // RL1
      urnf_pkg::URNF_FLT_63:  flt_len = `URNF_FLT_LEN_10;                // RL2
      urnf_pkg::URNF_FLT_127: flt_len = `URNF_FLT_LEN_11;                // RL2
      default:                flt_len = 7'h00;
    endcase
    next_cand = rx_line;
    next_cnt  = cnt;
    next_rx   = rx_filtered;
    if (rx_noise_filter_sel == urnf_pkg::URNF_FLT_OFF) begin
      // bypass still costs one register stage
      next_rx  = rx_line;                                                // RL1
      next_cnt = 7'h00;
    end else if (rx_line != cand) begin
      next_cnt = 7'h01;                                                  // RL6
    end else if (rx_line == rx_filtered) begin
      next_cnt = 7'h00;
    end else if (cnt + 7'h01 >= flt_len) begin
      next_rx  = rx_line;                                                // RL6
      next_cnt = 7'h00;
    end else begin
      next_cnt = cnt + 7'h01;                                            // RL6
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt         <= 7'h00;
      cand        <= `URNF_RX_IDLE;
      rx_filtered <= `URNF_RX_IDLE;
    end else begin
      cnt         <= next_cnt;
      cand        <= next_cand;
      rx_filtered <= next_rx;
    end
  end

  // ----------------------------------------
  // transfer clock
  // ----------------------------------------
  // barred filter/clock pairs are not checked here; software owns that
  urnf_baud_gen #(
    .TW (TW)
  ) u_baud (
    .clk_sys             (clk_sys),
    .rst_b               (rst_b),
    .baud_source_sel     (baud_source_sel),
    .timer_src_tick      (timer_src_tick),
    .timer_compare_value (timer_compare_value),
    .xfer_clk_tick       (xfer_clk_tick)
  );

  // ----------------------------------------
  // filter run-length monitor
  // ----------------------------------------
  // an independent count of how long the line has held its level;
  // pass_len_a and late_pass_a lean on it rather than on cnt, so a fault in the
  // filter arithmetic cannot hide behind itself
  logic [7:0] run_len;
  logic [7:0] next_run_len;
  logic       run_lvl;
  logic       next_run_lvl;
  logic [7:0] sel_age;
  logic [7:0] next_sel_age;
  logic [1:0] sel_prev;
  logic [1:0] next_sel_prev;
  logic [7:0] need_len;

  always_comb begin
    next_run_lvl  = rx_line;
    next_sel_prev = rx_noise_filter_sel;
    // both counts saturate so a long idle line cannot wrap them
    if (rx_line != run_lvl) begin
      next_run_len = 8'h01;
    end else begin
      next_run_len = run_len + {7'h00, ~&run_len};
    end
    if (rx_noise_filter_sel != sel_prev) begin
      next_sel_age = 8'h01;
    end else begin
      next_sel_age = sel_age + {7'h00, ~&sel_age};
    end
    case (urnf_pkg::urnf_flt_e'(sel_prev))
      urnf_pkg::URNF_FLT_31:  need_len = {1'b0, `URNF_FLT_LEN_01};
      urnf_pkg::URNF_FLT_63:  need_len = {1'b0, `URNF_FLT_LEN_10};
      urnf_pkg::URNF_FLT_127: need_len = {1'b0, `URNF_FLT_LEN_11};
      default:                need_len = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_len  <= 8'h00;
      run_lvl  <= `URNF_RX_IDLE;
      sel_age  <= 8'h00;
      sel_prev <= 2'h0;
    end else begin
      run_len  <= next_run_len;
      run_lvl  <= next_run_lvl;
      sel_age  <= next_sel_age;
      sel_prev <= next_sel_prev;
    end
  end

  // ----------------------------------------
  // timer divide monitor
  // ----------------------------------------
  // counts source ticks between transfer ticks; trusted only once a tick
  // has come from the timer with the source and compare value held since
  logic [TW-1:0] src_seen;
  logic [TW-1:0] next_src_seen;
  logic [TW-1:0] cmp_prev;
  logic [TW-1:0] next_cmp_prev;
  logic [TW-1:0] want_div;
  logic          tmr_was;
  logic          next_tmr_was;
  logic          tmr_run;
  logic          next_tmr_run;
  logic          tmr_hold;

  always_comb begin
    next_tmr_was  = (baud_source_sel == `URNF_BSEL_TIMER);
    next_cmp_prev = timer_compare_value;
    tmr_hold      = next_tmr_was && tmr_was &&
                    (timer_compare_value == cmp_prev);
    next_tmr_run  = tmr_hold && (xfer_clk_tick || tmr_run);
    next_src_seen = (xfer_clk_tick ? {TW{1'b0}} : src_seen) +
                    {{(TW-1){1'b0}}, timer_src_tick};
    // a compare of 0 divides by one, as the generator does
    want_div      = (cmp_prev == {TW{1'b0}}) ? {{(TW-1){1'b0}}, 1'b1} : cmp_prev;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      src_seen <= {TW{1'b0}};
      cmp_prev <= {TW{1'b0}};
      tmr_was  <= 1'b0;
      tmr_run  <= 1'b0;
    end else begin
      src_seen <= next_src_seen;
      cmp_prev <= next_cmp_prev;
      tmr_was  <= next_tmr_was;
      tmr_run  <= next_tmr_run;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_flip;
    $changed(rx_filtered);
  endsequence

  bypass_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_noise_filter_sel == 2'h0) |=> (rx_filtered == $past(rx_line)))
    else $error("bypass output not following line"); // RL1
  short31_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_noise_filter_sel == 2'h1)[*2] ##0 s_flip |-> (cnt == 7'h00) && $past(cnt) == 7'h1E)
    else $error("31 filter passed early or late"); // RL1
  short63_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_noise_filter_sel == 2'h2)[*2] ##0 s_flip |-> $past(cnt) == 7'h3E)
    else $error("63 filter passed early or late"); // RL2
  short127_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_noise_filter_sel == 2'h3)[*2] ##0 s_flip |-> $past(cnt) == 7'h7E)
    else $error("127 filter passed early or late"); // RL2
  restart_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_noise_filter_sel != 2'h0) && (rx_line != cand) |=> cnt == 7'h01)
    else $error("counter did not restart on change"); // RL6
  stable_out_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_noise_filter_sel != 2'h0) && (rx_line == rx_filtered) && (rx_line == cand)
    |=> $stable(rx_filtered))
    else $error("output moved without line change"); // RL6
  timer_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (baud_source_sel == 3'h6) && timer_src_tick && (timer_compare_value == 8'h01)
    |=> xfer_clk_tick)
    else $error("timer divide by one missed"); // RL3
  idle_code_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (baud_source_sel != 3'h0) && (baud_source_sel != 3'h6) |=> !xfer_clk_tick)
    else $error("tick on unsupported source code"); // RL4

  // whole current run seen under one filter length that is switched on
  sequence s_on_settled;
    (sel_prev != 2'h0) && (sel_age >= run_len);
  endsequence

  pass_len_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_on_settled ##0 s_flip |-> (run_len == need_len) && (rx_filtered == run_lvl))
    else $error("filter passed a level of the wrong length"); // RL6
  late_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_on_settled ##0 (run_len >= need_len) |-> (rx_filtered == run_lvl))
    else $error("filter held back a settled level"); // RL6
  timer_div_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tmr_run && xfer_clk_tick |-> (src_seen == want_div))
    else $error("timer transfer tick after wrong source count"); // RL3
  timer_miss_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tmr_run && !xfer_clk_tick |-> (src_seen < want_div))
    else $error("timer transfer tick missing"); // RL3
endmodule : urnf_rx_filter
`default_nettype wire

// ===== tb/urnf_tx_model.sv
`default_nettype none
module urnf_tx_model (
  input  wire logic clk_sys,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // remote sender, idles high between frames
  // ----------------------------------------
  initial rx_line = 1'b1;
  task automatic drive(input logic lvl, input int n);
    rx_line <= lvl;
    repeat (n) @(posedge clk_sys);
  endtask : drive
endmodule : urnf_tx_model
`default_nettype wire

// ===== tb/uart_rx_noise_filter_tb_top.sv
`default_nettype none
module uart_rx_noise_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0;
  logic       rst_b = 1'b0;
  logic [1:0] flt_sel = 2'h0;
  logic [2:0] baud_sel = 3'h1;
  logic       tmr_tick = 1'b0;
  logic [7:0] cmp_val = 8'h03;
  wire logic  rx_line;
  logic       rx_filtered;
  logic       xfer_clk_tick;
  int         mismatches = 0;
  int         check_count = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tmr_tick <= ~tmr_tick;
  urnf_tx_model u_tx (.clk_sys(clk_sys), .rx_line(rx_line));
  urnf_rx_filter #(.TW(8)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .rx_line(rx_line),
    .rx_noise_filter_sel(flt_sel), .baud_source_sel(baud_sel), .timer_src_tick(tmr_tick),
    .timer_compare_value(cmp_val), .rx_filtered(rx_filtered), .xfer_clk_tick(xfer_clk_tick));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic close_out();
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // for n > 1 a low glitch of n-1 samples must vanish; a full-length low must pass after n samples
  task automatic run_filter(input logic [1:0] sel, input int n);
    int c;
    @(posedge clk_sys);
    flt_sel <= sel;
    u_tx.drive(1'b1, 4);
    if (n > 1) begin
      u_tx.drive(1'b0, n - 1);
      u_tx.drive(1'b1, 2);
      #1;
      check("glitch", {7'h00, rx_filtered}, 8'h01);
    end
    @(posedge clk_sys);
    u_tx.drive(1'b0, 0);
    for (c = 1; c < 200; c++) begin
      @(posedge clk_sys);
      #1;
      if (rx_filtered === 1'b0) break;
    end
    check("pass_delay", 8'(c), 8'(n));
    @(posedge clk_sys);
    u_tx.drive(1'b1, n + 4);
  endtask : run_filter
  // gap between ticks, capped at 60 so a silent source shows as 60
  task automatic run_baud(input logic [2:0] sel, input logic [7:0] cmp, input logic [7:0] exp);
    int c;
    @(posedge clk_sys);
    baud_sel <= sel;
    cmp_val <= cmp;
    repeat (30) @(posedge clk_sys);
    #1;
    for (c = 0; c < 60 && xfer_clk_tick !== 1'b1; c++) begin
      @(posedge clk_sys);
      #1;
    end
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (c < 60 && xfer_clk_tick !== 1'b1);
    check("tick_gap", 8'(c), exp);
  endtask : run_baud
  initial begin
    repeat (4) @(posedge clk_sys);
    check("rst_tick", {7'h00, xfer_clk_tick}, 8'h00);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("rst_line", {7'h00, rx_filtered}, 8'h01);
    run_filter(2'h0, 1);
    run_filter(2'h1, 31);
    run_filter(2'h2, 63);
    run_filter(2'h3, 127);
    // filter off is legal with every clock source
    flt_sel <= 2'h0;
    run_baud(3'h0, 8'h03, 8'h0D);
    run_baud(3'h6, 8'h03, 8'h06);
    run_baud(3'h6, 8'h05, 8'h0A);
    run_baud(3'h6, 8'h01, 8'h02);
    run_baud(3'h1, 8'h05, 8'h3C);
    run_baud(3'h3, 8'h05, 8'h3C);
    close_out();
  end
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule : uart_rx_noise_filter_tb_top
`default_nettype wire
